//--- pkg/cix_pkg.sv
// Purpose: Constants, types and shared arithmetic for the instruction execute block.
// Assumes: Internal RAM and hardware registers answer a read in the same cycle.
// Notes: Opcodes are grouped by high nibble; low nibble selects the source mode.
// Notes on behaviour
// - Bit set forces target to one, flags kept.
// - Short jump always branches, no condition.
// - Target is PC plus two plus displacement.
// - Displacement is signed, minus 128 to 127.
// - Subtract operand and carry from accumulator.
// - Carry set on borrow out of bit 7.
// - Auxiliary carry set on borrow from bit 3.
// - Overflow when borrow out of bit 6 xor out of bit 7.
// - Subtract source: register, direct, indirect, immediate.
// - Nibble swap exchanges accumulator halves, flags kept.
// - Byte exchange swaps accumulator with operand.
// - Digit exchange swaps low nibbles via pointer.
// - Exclusive-OR stores result, flags kept.
// - Six exclusive-OR operand combinations are decoded.
// - Direct destination inverts bits chosen by mask.
// - Port read-modify-write reads the output latch.
package cix_pkg;
    localparam logic [7:0] OPC_SET_CARRY = 8'hd3;
    localparam logic [7:0] OPC_SET_BIT = 8'hd2;
    localparam logic [7:0] OPC_SHORT_JUMP = 8'h80;
    localparam logic [7:0] OPC_SUB_IMM = 8'h94;
    localparam logic [7:0] OPC_SWAP = 8'hc4;
    localparam logic [7:0] OPC_EOR_IMM = 8'h64;
    localparam logic [7:0] OPC_EOR_DIR_ACC = 8'h62;
    localparam logic [7:0] OPC_EOR_DIR_IMM = 8'h63;
    localparam logic [6:0] OPC_DIGIT_EXCH_PAIR = 7'h6b;
    localparam logic [3:0] FAM_SUB = 4'h9;
    localparam logic [3:0] FAM_EOR = 4'h6;
    localparam logic [3:0] FAM_EXCH = 4'hc;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [3:0] LO_REG = 4'h8;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [15:0] PC_STEP_JUMP = 16'h0002;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_PTR = 2'b01, ST_OPR = 2'b11, ST_WR = 2'b10
    } cix_state_t;
    typedef enum logic [3:0] {
        OP_NONE, OP_SET_CARRY, OP_SET_BIT, OP_JUMP, OP_SUB, OP_SWAP,
        OP_EXCH, OP_DIGIT, OP_EOR_ACC, OP_EOR_DIR_ACC, OP_EOR_DIR_IMM
    } cix_op_t;
    typedef enum logic [2:0] {MD_NONE, MD_REG, MD_DIR, MD_IND, MD_IMM, MD_BIT} cix_mode_t;

    // Returns {carry, aux carry, overflow, difference}.
    function automatic logic [10:0] cix_sub_borrow(input logic [7:0] a, input logic [7:0] b,
                                                   input logic cy);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] mid;
        full = {1'b0, a} - {1'b0, b} - {8'h00, cy};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy};
        mid = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, cy};
        return {full[8], low[4], mid[7] ^ full[8], full[7:0]};
    endfunction : cix_sub_borrow

    function automatic logic [15:0] cix_rel_target(input logic [15:0] pc, input logic [7:0] rel);
        return pc + PC_STEP_JUMP + {{8{rel[7]}}, rel};
    endfunction : cix_rel_target

    function automatic logic [7:0] cix_reg_addr(input logic [1:0] bank, input logic [2:0] num);
        return {3'b000, bank, num};
    endfunction : cix_reg_addr
endpackage : cix_pkg

//--- rtl/cix_exec.sv
// Purpose: Executes bit set, short jump, subtract, swap, exchanges and exclusive-OR.
// Assumes: Data space read data is valid in the cycle the read strobe is high.
// Notes: Accumulator, flags and program counter are held here.
`timescale 1ns/1ps
module cix_exec (
    // Clock and reset
    input logic mclk_i,
    input logic rst_b_i,
    // Instruction from fetch
    input logic instr_valid_i,
    output logic instr_ready_o,
    input logic [7:0] opcode_i,
    input logic [7:0] byte1_i,
    input logic [7:0] byte2_i,
    input logic [1:0] reg_bank_i,
    // Data space
    output logic [7:0] data_addr_o,
    output logic data_rd_o,
    output logic data_rmw_o,
    output logic data_ind_o,
    input logic [7:0] data_rdata_i,
    output logic data_wr_o,
    output logic [7:0] data_wdata_o,
    // Core state
    output logic [7:0] acc_o,
    output logic carry_o,
    output logic aux_o,
    output logic ovf_o,
    output logic [15:0] pc_o,
    output logic done_o,
    output logic illegal_o
);
    import cix_pkg::*;

    typedef struct packed {
        cix_state_t st;
        cix_op_t op;
        logic [7:0] acc;
        logic [7:0] imm;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [15:0] pc;
        logic cy;
        logic aux;
        logic ovf;
        logic rd;
        logic wr;
        logic rmw;
        logic ind;
        logic done;
        logic illegal;
    } cix_regs_t;

    typedef struct packed {
        cix_op_t op;
        cix_mode_t mode;
        logic [15:0] len;
    } cix_dec_t;

    localparam cix_regs_t REGS_RST = '{st: ST_IDLE, op: OP_NONE, acc: ACC_RST,
        imm: 8'h00, addr: 8'h00, wdata: 8'h00, pc: PC_RST, cy: 1'b0, aux: 1'b0,
        ovf: 1'b0, rd: 1'b0, wr: 1'b0, rmw: 1'b0, ind: 1'b0, done: 1'b0, illegal: 1'b0};

    cix_regs_t r_reg;
    cix_regs_t r_next;

    function automatic cix_mode_t src_mode(input logic [3:0] lo);
        if (lo >= LO_REG) begin
            return MD_REG;
        end else if (lo == LO_IMM) begin
            return MD_IMM;
        end else if (lo == LO_DIR) begin
            return MD_DIR;
        end
        return MD_IND;
    endfunction : src_mode

    function automatic cix_dec_t decode(input logic [7:0] opc);
        cix_dec_t d;
        d = '{op: OP_NONE, mode: MD_NONE, len: 16'h0001};
        if (opc == OPC_SET_CARRY) begin
            d.op = OP_SET_CARRY;
        end else if (opc == OPC_SET_BIT) begin
            d.op = OP_SET_BIT;
            d.mode = MD_BIT;
        end else if (opc == OPC_SHORT_JUMP) begin
            d.op = OP_JUMP;
        end else if (opc == OPC_SWAP) begin
            d.op = OP_SWAP;
        end else if (opc[7:1] == OPC_DIGIT_EXCH_PAIR) begin
            d.op = OP_DIGIT;
            d.mode = MD_IND;
        end else if (opc == OPC_EOR_DIR_ACC) begin
            d.op = OP_EOR_DIR_ACC;
            d.mode = MD_DIR;
        end else if (opc == OPC_EOR_DIR_IMM) begin
            d.op = OP_EOR_DIR_IMM;
            d.mode = MD_DIR;
        end else if (opc[7:4] == FAM_SUB && opc[3:0] >= LO_IMM) begin
            d.op = OP_SUB;
            d.mode = src_mode(opc[3:0]);
        end else if (opc[7:4] == FAM_EOR && opc[3:0] >= LO_IMM) begin
            d.op = OP_EOR_ACC;
            d.mode = src_mode(opc[3:0]);
        end else if (opc[7:4] == FAM_EXCH && opc[3:0] >= LO_DIR) begin
            d.op = OP_EXCH;
            d.mode = src_mode(opc[3:0]);
        end
        if (d.op == OP_EOR_DIR_IMM) begin
            d.len = 16'h0003;
        end else if (d.mode == MD_DIR || d.mode == MD_IMM || d.mode == MD_BIT ||
                     d.op == OP_JUMP) begin
            d.len = 16'h0002;
        end
        return d;
    endfunction : decode

    // Accumulator operations shared by the immediate and memory source paths.
    // Returns {acc, carry, aux carry, overflow}.
    function automatic logic [10:0] acc_op(input cix_op_t op, input logic [7:0] a,
                                           input logic [7:0] b, input logic cy,
                                           input logic aux, input logic ovf);
        logic [10:0] s;
        if (op == OP_SUB) begin
            s = cix_sub_borrow(a, b, cy);
            return {s[7:0], s[10:8]};
        end
        return {a ^ b, cy, aux, ovf};
    endfunction : acc_op

    always_comb begin
        cix_dec_t d;
        d = decode(opcode_i);
        r_next = r_reg;
        r_next.rd = 1'b0;
        r_next.wr = 1'b0;
        r_next.rmw = 1'b0;
        r_next.ind = 1'b0;
        r_next.done = 1'b0;
        r_next.illegal = 1'b0;
        unique case (r_reg.st)
            ST_IDLE: begin
                if (instr_valid_i) begin
                    r_next.op = d.op;
                    r_next.imm = (d.op == OP_EOR_DIR_IMM) ? byte2_i : byte1_i;
                    r_next.pc = r_reg.pc + d.len;
                    unique case (d.mode)
                        MD_REG: begin
                            // Register number sits in the three low opcode bits.
                            r_next.addr = cix_reg_addr(reg_bank_i, opcode_i[2:0]);
                            r_next.rd = 1'b1;
                            r_next.st = ST_OPR;
                        end
                        MD_DIR: begin
                            r_next.addr = byte1_i;
                            r_next.rd = 1'b1;
                            // Port destinations must be read from the latch, not the pins.
                            r_next.rmw = (d.op == OP_EOR_DIR_ACC || d.op == OP_EOR_DIR_IMM);
                            r_next.st = ST_OPR;
                        end
                        MD_BIT: begin
                            r_next.addr = byte1_i[7] ? {byte1_i[7:3], 3'b000} :
                                          BIT_AREA_BASE + {4'h0, byte1_i[6:3]};
                            r_next.rd = 1'b1;
                            r_next.rmw = 1'b1;
                            r_next.st = ST_OPR;
                        end
                        MD_IND: begin
                            r_next.addr = cix_reg_addr(reg_bank_i, {2'b00, opcode_i[0]});
                            r_next.rd = 1'b1;
                            r_next.st = ST_PTR;
                        end
                        MD_IMM: begin
                            {r_next.acc, r_next.cy, r_next.aux, r_next.ovf} =
                                acc_op(d.op, r_reg.acc, byte1_i, r_reg.cy, r_reg.aux, r_reg.ovf);
                            r_next.done = 1'b1;
                        end
                        MD_NONE: begin
                            r_next.done = 1'b1;
                            if (d.op == OP_SET_CARRY) begin
                                r_next.cy = 1'b1;
                            end else if (d.op == OP_SWAP) begin
                                r_next.acc = {r_reg.acc[3:0], r_reg.acc[7:4]};
                            end else if (d.op == OP_JUMP) begin
                                // Unconditional; the length step is replaced by the target.
                                r_next.pc = cix_rel_target(r_reg.pc, byte1_i);
                            end else begin
                                r_next.illegal = 1'b1;
                            end
                        end
                        default: begin
                            r_next.illegal = 1'b1;
                            r_next.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_PTR: begin
                r_next.addr = data_rdata_i;
                r_next.rd = 1'b1;
                r_next.ind = 1'b1;
                r_next.st = ST_OPR;
            end
            ST_OPR: begin
                r_next.ind = r_reg.ind;
                r_next.wr = 1'b1;
                r_next.st = ST_WR;
                unique case (r_reg.op)
                    OP_EXCH: begin
                        r_next.acc = data_rdata_i;
                        r_next.wdata = r_reg.acc;
                    end
                    OP_DIGIT: begin
                        r_next.acc = {r_reg.acc[7:4], data_rdata_i[3:0]};
                        r_next.wdata = {data_rdata_i[7:4], r_reg.acc[3:0]};
                    end
                    OP_EOR_DIR_ACC: begin
                        r_next.wdata = data_rdata_i ^ r_reg.acc;
                    end
                    OP_EOR_DIR_IMM: begin
                        r_next.wdata = data_rdata_i ^ r_reg.imm;
                    end
                    OP_SET_BIT: begin
                        r_next.wdata = data_rdata_i | (8'h01 << r_reg.imm[2:0]);
                    end
                    default: begin
                        r_next.wr = 1'b0;
                        r_next.ind = 1'b0;
                        r_next.st = ST_IDLE;
                        r_next.done = 1'b1;
                        {r_next.acc, r_next.cy, r_next.aux, r_next.ovf} =
                            acc_op(r_reg.op, r_reg.acc, data_rdata_i, r_reg.cy, r_reg.aux,
                                   r_reg.ovf);
                    end
                endcase
            end
            ST_WR: begin
                r_next.done = 1'b1;
                r_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            r_reg <= REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign instr_ready_o = (r_reg.st == ST_IDLE);
    assign data_addr_o = r_reg.addr;
    assign data_rd_o = r_reg.rd;
    assign data_rmw_o = r_reg.rmw;
    assign data_ind_o = r_reg.ind;
    assign data_wr_o = r_reg.wr;
    assign data_wdata_o = r_reg.wdata;
    assign acc_o = r_reg.acc;
    assign carry_o = r_reg.cy;
    assign aux_o = r_reg.aux;
    assign ovf_o = r_reg.ovf;
    assign pc_o = r_reg.pc;
    assign done_o = r_reg.done;
    assign illegal_o = r_reg.illegal;

    // Checks on the execute behaviour.
    logic accept;
    assign accept = instr_valid_i && instr_ready_o;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    chk_set_carry: assert property (
        accept && opcode_i == OPC_SET_CARRY |=> carry_o && done_o && $stable(acc_o)
            && $stable(aux_o) && $stable(ovf_o))
        else $error("carry not set alone");
    chk_jump_target: assert property (
        accept && opcode_i == OPC_SHORT_JUMP |=> done_o
            && pc_o == cix_rel_target($past(pc_o), $past(byte1_i)))
        else $error("short jump target wrong");
    chk_sub_flags: assert property (
        accept && opcode_i == OPC_SUB_IMM |=> {carry_o, aux_o, ovf_o, acc_o}
            == cix_sub_borrow($past(acc_o), $past(byte1_i), $past(carry_o)))
        else $error("subtract result or flags wrong");
    chk_sub_reg: assert property (
        accept && opcode_i[7:3] == {FAM_SUB, 1'b1} |=> data_rd_o && !data_rmw_o
            && data_addr_o == cix_reg_addr($past(reg_bank_i), $past(opcode_i[2:0])) ##1 done_o)
        else $error("register source not read");
    chk_swap_nibble: assert property (
        accept && opcode_i == OPC_SWAP |=> acc_o == {$past(acc_o[3:0]), $past(acc_o[7:4])}
            && $stable(carry_o) && $stable(ovf_o))
        else $error("nibble swap wrong");
    chk_exch_swap: assert property (
        r_reg.st == ST_OPR && r_reg.op == OP_EXCH |=> data_wr_o
            && data_wdata_o == $past(acc_o) && acc_o == $past(data_rdata_i))
        else $error("byte exchange wrong");
    chk_digit_pointer: assert property (
        accept && opcode_i[7:1] == OPC_DIGIT_EXCH_PAIR |=> data_rd_o
            && data_addr_o == cix_reg_addr($past(reg_bank_i), {2'b00, $past(opcode_i[0])})
            ##1 data_rd_o && data_ind_o ##1 data_wr_o && data_ind_o)
        else $error("digit exchange pointer wrong");
    chk_digit_swap: assert property (
        r_reg.st == ST_OPR && r_reg.op == OP_DIGIT |=> $stable(carry_o)
            && data_wdata_o == {$past(data_rdata_i[7:4]), $past(acc_o[3:0])}
            && acc_o == {$past(acc_o[7:4]), $past(data_rdata_i[3:0])})
        else $error("digit exchange wrong");
    chk_eor_imm: assert property (
        accept && opcode_i == OPC_EOR_IMM |=> acc_o == ($past(acc_o) ^ $past(byte1_i))
            && $stable(carry_o) && $stable(aux_o) && $stable(ovf_o))
        else $error("exclusive-or to accumulator wrong");
    chk_eor_latch: assert property (
        accept && opcode_i == OPC_EOR_DIR_ACC |=> data_rd_o && data_rmw_o
            && data_addr_o == $past(byte1_i)
            ##1 data_wr_o && data_wdata_o == ($past(data_rdata_i) ^ acc_o))
        else $error("exclusive-or to direct byte wrong");

    cov_jump: cover property (accept && opcode_i == OPC_SHORT_JUMP ##1 done_o);
    // Digit exchange finishes four cycles after accept: pointer, read, write, done.
    cov_digit: cover property (accept && opcode_i[7:1] == OPC_DIGIT_EXCH_PAIR ##4 done_o);
    cov_eor_dir_imm: cover property (accept && opcode_i == OPC_EOR_DIR_IMM ##2 data_wr_o);
endmodule : cix_exec

//--- bench/cix_mem_model.sv
// Purpose: Data space seen by the execute block: internal RAM, upper RAM and one output port.
// Assumes: Reads answer in the same cycle as the read strobe; writes land on the clock edge.
// Notes: Idle read data shows the inverse of the last answer, so a stray sample cannot pass.
`timescale 1ns/1ps
module cix_mem_model #(
    parameter logic [7:0] PORT_ADDR = 8'h90,
    parameter logic [7:0] PIN_VAL = 8'h5a
) (
    // Clock
    input wire logic mclk_i,
    // Data space from the block
    input wire logic [7:0] data_addr_i,
    input wire logic data_rd_i,
    input wire logic data_rmw_i,
    input wire logic data_ind_i,
    input wire logic data_wr_i,
    input wire logic [7:0] data_wdata_i,
    output logic [7:0] data_rdata_o
);
    // Index 384 and up is upper RAM, reached only by indirect access.
    logic [7:0] mem [0:511];
    logic [7:0] last_reg;
    logic [8:0] idx;

    assign idx = {data_ind_i & data_addr_i[7], data_addr_i};

    always_comb begin
        if (!data_rd_i) begin
            data_rdata_o = ~last_reg;
        end else if (!data_ind_i && !data_rmw_i && data_addr_i == PORT_ADDR) begin
            // A plain read of the port sees the pins, which differ from the latch.
            data_rdata_o = PIN_VAL;
        end else begin
            data_rdata_o = mem[idx];
        end
    end

    always @(posedge mclk_i) begin
        if (data_rd_i) begin
            last_reg <= data_rdata_o;
        end
        if (data_wr_i) begin
            mem[idx] <= data_wdata_i;
        end
    end
endmodule : cix_mem_model

//--- bench/tb.sv
// Purpose: Self-checking bench for the execute block with corner and random instructions.
// Assumes: The data space model answers reads in the same cycle.
// Notes: A reference model tracks accumulator, flags, program counter and memory.
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] PORT_ADDR = 8'h90;
    localparam logic [7:0] PIN_VAL = 8'h5a;
    logic mclk_i, rst_b_i, instr_valid_i, instr_ready_o, data_rd_o, data_rmw_o, data_ind_o;
    logic data_wr_o, carry_o, aux_o, ovf_o, done_o, illegal_o;
    logic [7:0] opcode_i, byte1_i, byte2_i, data_addr_o, data_rdata_i, data_wdata_o, acc_o;
    logic [1:0] reg_bank_i;
    logic [15:0] pc_o;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] ref_mem [0:511];
    logic [7:0] r_acc, op;
    logic r_cy, r_aux, r_ovf, r_ill, r_wr;
    logic [15:0] r_pc;
    logic [8:0] r_wk;
    logic [7:0] ops [0:20] = '{8'hd3, 8'hd2, 8'h80, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'hc4,
        8'hc5, 8'hc6, 8'hc7, 8'hc8, 8'hd6, 8'hd7, 8'h64, 8'h65, 8'h66, 8'h68, 8'h62, 8'h63};
    logic [23:0] cor [0:15] = '{24'h808000, 24'h807f00, 24'h80fe00, 24'hd30000, 24'hd29000,
        24'hd20700, 24'h629000, 24'h639031, 24'hc59000, 24'h94ff00, 24'ha50000, 24'hc40000,
        24'hd70000, 24'hc70000, 24'h670000, 24'h9e0000};

    cix_exec i_cix_exec (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
        .instr_ready_o(instr_ready_o), .opcode_i(opcode_i), .byte1_i(byte1_i),
        .byte2_i(byte2_i), .reg_bank_i(reg_bank_i), .data_addr_o(data_addr_o),
        .data_rd_o(data_rd_o), .data_rmw_o(data_rmw_o), .data_ind_o(data_ind_o),
        .data_rdata_i(data_rdata_i), .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o),
        .acc_o(acc_o), .carry_o(carry_o), .aux_o(aux_o), .ovf_o(ovf_o), .pc_o(pc_o),
        .done_o(done_o), .illegal_o(illegal_o));

    cix_mem_model #(.PORT_ADDR(PORT_ADDR), .PIN_VAL(PIN_VAL)) i_cix_mem_model (
        .mclk_i(mclk_i), .data_addr_i(data_addr_o), .data_rd_i(data_rd_o),
        .data_rmw_i(data_rmw_o), .data_ind_i(data_ind_o), .data_wr_i(data_wr_o),
        .data_wdata_i(data_wdata_o), .data_rdata_o(data_rdata_i));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] rdr(input logic [7:0] a, input logic ind, input logic rmw);
        if (!ind && !rmw && a == PORT_ADDR) begin
            return PIN_VAL;
        end
        return ref_mem[{ind & a[7], a}];
    endfunction : rdr

    task automatic model(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                         input logic [1:0] bk);
        logic [7:0] ea, v, t;
        logic ind;
        int a, b, c, len;
        ind = 1'b0;
        len = 1;
        r_wr = 1'b0;
        r_ill = 1'b0;
        ea = 8'h00;
        t = r_acc;
        if (op[3]) begin
            ea = {3'b000, bk, op[2:0]};
        end else if (op[3:0] == 4'h5) begin
            ea = b1;
            len = 2;
        end else if (op[3:1] == 3'b011) begin
            ea = ref_mem[{4'h0, bk, 2'b00, op[0]}];
            ind = 1'b1;
        end
        v = rdr(ea, ind, 1'b0);
        casez (op)
            8'hd3: r_cy = 1'b1;
            8'hd2: begin
                len = 2;
                ea = b1[7] ? {b1[7:3], 3'b000} : 8'h20 + {4'h0, b1[6:3]};
                t = rdr(ea, 1'b0, 1'b1) | (8'h01 << b1[2:0]);
                r_wr = 1'b1;
            end
            8'h80: begin
                len = 0;
                r_pc = r_pc + 16'h0002 + {{8{b1[7]}}, b1};
            end
            8'hc4: r_acc = {r_acc[3:0], r_acc[7:4]};
            8'h94, 8'h95, 8'b1001_011?, 8'b1001_1???: begin
                if (op == 8'h94) begin
                    v = b1;
                    len = 2;
                end
                a = r_acc;
                b = v;
                c = r_cy;
                r_cy = a < b + c;
                r_aux = (a % 16) < (b % 16) + c;
                r_ovf = ((a % 128) < (b % 128) + c) ^ r_cy;
                r_acc = 8'(a - b - c);
            end
            8'h64, 8'h65, 8'b0110_011?, 8'b0110_1???: begin
                if (op == 8'h64) begin
                    v = b1;
                    len = 2;
                end
                r_acc = r_acc ^ v;
            end
            8'h62, 8'h63: begin
                ea = b1;
                len = op[0] ? 3 : 2;
                t = rdr(b1, 1'b0, 1'b1) ^ (op[0] ? b2 : r_acc);
                r_wr = 1'b1;
            end
            8'hc5, 8'b1100_011?, 8'b1100_1???: begin
                r_acc = v;
                r_wr = 1'b1;
            end
            8'b1101_011?: begin
                t = {v[7:4], r_acc[3:0]};
                r_acc = {r_acc[7:4], v[3:0]};
                r_wr = 1'b1;
            end
            default: begin
                r_ill = 1'b1;
                len = 1;
            end
        endcase
        r_pc = r_pc + 16'(len);
        r_wk = {ind & ea[7], ea};
        if (r_wr) begin
            ref_mem[r_wk] = t;
        end
    endtask : model

    task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                       input logic [1:0] bk);
        int n;
        model(op, b1, b2, bk);
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        opcode_i <= op;
        byte1_i <= b1;
        byte2_i <= b2;
        reg_bank_i <= bk;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        n = 0;
        #1;
        // Longest form finishes four cycles after accept; eight leaves margin.
        while (done_o !== 1'b1 && n < 8) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check("done", {15'h0000, done_o}, 16'h0001);
        check("ready", {15'h0000, instr_ready_o}, 16'h0001);
        check("illegal", {15'h0000, illegal_o}, {15'h0000, r_ill});
        check("acc", {8'h00, acc_o}, {8'h00, r_acc});
        check("carry", {15'h0000, carry_o}, {15'h0000, r_cy});
        check("aux", {15'h0000, aux_o}, {15'h0000, r_aux});
        check("overflow", {15'h0000, ovf_o}, {15'h0000, r_ovf});
        check("pc", pc_o, r_pc);
        if (r_wr) begin
            check("mem", {8'h00, i_cix_mem_model.mem[r_wk]}, {8'h00, ref_mem[r_wk]});
        end
        @(posedge mclk_i);
        #1;
        check("done pulse", {15'h0000, done_o}, 16'h0000);
    endtask : run

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // About 316 instructions of at most ten cycles each fit well inside this span.
    initial begin
        #600000;
        num_errors++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        rst_b_i = 1'b0;
        instr_valid_i = 1'b0;
        opcode_i = 8'h00;
        byte1_i = 8'h00;
        byte2_i = 8'h00;
        reg_bank_i = 2'b00;
        void'($urandom(73));
        for (int i = 0; i < 512; i++) begin
            ref_mem[i] = 8'($urandom);
            i_cix_mem_model.mem[i] = ref_mem[i];
        end
        {r_acc, r_cy, r_aux, r_ovf, r_pc} = '0;
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        #1;
        check("reset acc", {8'h00, acc_o}, 16'h0000);
        check("reset flags", {13'h0000, carry_o, aux_o, ovf_o}, 16'h0000);
        check("reset pc", pc_o, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            run(cor[i][23:16], cor[i][15:8], cor[i][7:0], 2'(i));
        end
        $display("test corners done");
        for (int i = 0; i < 300; i++) begin
            op = ops[$urandom_range(0, 20)];
            if (op[3]) begin
                op[2:0] = 3'($urandom);
            end
            run(op, 8'($urandom), 8'($urandom), 2'($urandom));
        end
        $display("test random done");
        stop_test();
    end
endmodule : tb
